// ==== logic/cgrpc_top.v ====
// Behaviour
// - low nibble picks bit clock rate
// - bit clock scaled by actual/named rate
// - plus-200 bit adds 200 Hz
// - both nibbles 1111 gives 128x conversion
// - video lock: field sets conversion rate
// - video base decoded from bits 6:4
// - bits 2:0 give divisor one to eight
// - mode resets 00ff, held in reset/power-down
// - sample-rate value used when not sync-referenced
// - sample rate resets bb80, held likewise
// - direction bit: 0 advance, 1 retard
// - magnitude decremented at 3.072 MHz
// - read gives remaining; write may replace
// - video lock: both bits set, no bit clock

`include "cgrpc_regs.vh"

module cgrpc_top (
  input wire core_clk,
  input wire nrst,
  input wire power_down_n,
  input wire [5:0] ctrl_addr,
  input wire [15:0] ctrl_wdata,
  input wire ctrl_wr,
  input wire ctrl_rd,
  output reg [15:0] ctrl_rdata_r,
  output reg bit_clock_out_r,
  output reg [16:0] conv_rate_hz_r,
  output reg video_mode_r,
  output reg phase_adv_pulse_r,
  output reg phase_ret_pulse_r,
  output reg [15:0] mode_r,
  output reg [15:0] rate_r
);

  reg [15:0] phase_r;
  reg [15:0] phase_nxt;
  reg [47:0] nco_acc_r;
  reg [47:0] nco_acc_nxt;
  reg bit_clock_nxt;
  reg [16:0] tick_acc_r;
  reg [16:0] tick_acc_nxt;
  reg tick;
  reg [15:0] rdata_nxt;
  reg [18:0] actual_x7;
  reg [31:0] conv_tmp;
  reg [31:0] tick_sum;

  wire [14:0] bit_rate_hz;
  wire [16:0] named_rate_x7;
  wire [15:0] video_rate_hz;
  wire ref_sync = mode_r[`CGRPC_BIT_REF];
  wire video_lock = mode_r[`CGRPC_BIT_REF] & mode_r[`CGRPC_BIT_VID];
  wire x128_mode = (mode_r[7:0] == 8'hff);
  wire [47:0] nco_step;
  wire [47:0] nco_thr;
  wire [47:0] nco_sum;
  wire wr_ok = ctrl_wr & power_down_n;
  // a phase write in the same cycle as a tick wins over the decrement
  wire phase_wr = wr_ok & (ctrl_addr == `CGRPC_ADDR_PHASE);
  // a count is consumed only from the crystal reference, never while powered down
  wire phase_take = tick & ~ref_sync & power_down_n & (phase_r[7:0] != 8'h00) & ~phase_wr;

  cgrpc_rate_decode u_decode (
    .rate_modifier_field(mode_r[7:0]),
    .plus_200hz_modifier(mode_r[`CGRPC_BIT_P200]),
    .bit_rate_hz(bit_rate_hz),
    .named_rate_x7(named_rate_x7),
    .video_rate_hz(video_rate_hz)
  );

  // mode and sample-rate registers; power-down forces defaults and blocks writes
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= `CGRPC_MODE_RESET;
      rate_r <= `CGRPC_RATE_RESET;
    end else if (!power_down_n) begin
      mode_r <= `CGRPC_MODE_RESET;
      rate_r <= `CGRPC_RATE_RESET;
    end else if (wr_ok) begin
      if (ctrl_addr == `CGRPC_ADDR_MODE) begin
        mode_r <= ctrl_wdata & `CGRPC_MODE_WMASK;
      end
      if (ctrl_addr == `CGRPC_ADDR_RATE) begin
        rate_r <= ctrl_wdata;
      end
    end
  end

  // actual conversion rate in units of 1/7 Hz
  always @* begin
    if (ref_sync && !x128_mode) begin
      // locked to sync: the true rate is unknown here, assume the named one
      actual_x7 = {2'b00, named_rate_x7};
    end else if (mode_r[`CGRPC_BIT_X87] && !ref_sync) begin
      actual_x7 = {rate_r, 3'b000};
    end else begin
      actual_x7 = {rate_r, 3'b000} - {3'b000, rate_r};
    end
  end

  // nco: toggles at 2 * bit_rate * actual / named, so output = bit_rate * actual / named
  assign nco_step = {33'd0, bit_rate_hz} * {29'd0, actual_x7};
  assign nco_thr = {31'd0, named_rate_x7} * (`CGRPC_CLK_HZ / 2);
  assign nco_sum = nco_acc_r + nco_step;

  always @* begin
    nco_acc_nxt = nco_sum;
    bit_clock_nxt = bit_clock_out_r;
    if (video_lock || !power_down_n || bit_rate_hz == 15'h0000 || named_rate_x7 == 17'h00000) begin
      // no bit clock in video lock or on reserved codes
      nco_acc_nxt = 48'h0;
      bit_clock_nxt = 1'b0;
    end else if (nco_sum >= nco_thr) begin
      // a smaller threshold after a rate change would leave the sum out of range and
      // toggle every cycle until it drained, so restart the period instead
      if (nco_acc_r >= nco_thr) begin
        nco_acc_nxt = 48'h0;
      end else begin
        nco_acc_nxt = nco_sum - nco_thr;
      end
      bit_clock_nxt = ~bit_clock_out_r;
    end
  end

  // bit clock output and its accumulator
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      nco_acc_r <= 48'h0;
      bit_clock_out_r <= 1'b0;
    end else begin
      nco_acc_r <= nco_acc_nxt;
      bit_clock_out_r <= bit_clock_nxt;
    end
  end

  // fractional tick at 3.072 MHz from the 100 MHz clock, no long-term drift
  always @* begin
    tick_sum = {15'h0000, tick_acc_r} + `CGRPC_PHASE_TICK_KHZ;
    tick = 1'b0;
    if (tick_sum >= `CGRPC_CLK_KHZ) begin
      tick_sum = tick_sum - `CGRPC_CLK_KHZ;
      tick = 1'b1;
    end
    // remainder stays below the clock rate in kHz, so the slice drops only zeros
    tick_acc_nxt = tick_sum[16:0];
  end

  // phase register: a write replaces whatever is still pending
  always @* begin
    phase_nxt = phase_r;
    if (!power_down_n) begin
      phase_nxt = `CGRPC_PHASE_RESET;
    end else if (phase_wr) begin
      phase_nxt = ctrl_wdata & `CGRPC_PHASE_WMASK;
    end else if (phase_take) begin
      phase_nxt = phase_r - 16'h0001;
    end
  end

  // tick accumulator, phase count and the count pulses
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_acc_r <= 17'h0;
      phase_r <= `CGRPC_PHASE_RESET;
      phase_adv_pulse_r <= 1'b0;
      phase_ret_pulse_r <= 1'b0;
    end else begin
      tick_acc_r <= tick_acc_nxt;
      phase_r <= phase_nxt;
      // one pulse per consumed count, but not on the cycle a write lands
      phase_adv_pulse_r <= phase_take & ~phase_r[`CGRPC_BIT_PDIR];
      phase_ret_pulse_r <= phase_take & phase_r[`CGRPC_BIT_PDIR];
    end
  end

  // effective conversion rate for the converters
  always @* begin
    if (video_lock) begin
      conv_tmp = {16'h0000, video_rate_hz};
    end else if (ref_sync) begin
      conv_tmp = {15'h0000, named_rate_x7} / 7;
    end else begin
      conv_tmp = {13'h0000, actual_x7} / 7;
    end
  end

  // read data returned the cycle after the read strobe; unmapped reads zero
  always @* begin
    case (ctrl_addr)
      `CGRPC_ADDR_MODE: rdata_nxt = mode_r;
      `CGRPC_ADDR_RATE: rdata_nxt = rate_r;
      `CGRPC_ADDR_PHASE: rdata_nxt = phase_r;
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // registered outputs: read data holds until the next read strobe
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_rdata_r <= 16'h0000;
      conv_rate_hz_r <= 17'h0;
      video_mode_r <= 1'b0;
    end else begin
      if (ctrl_rd) begin
        ctrl_rdata_r <= rdata_nxt;
      end
      conv_rate_hz_r <= conv_tmp[16:0];
      video_mode_r <= video_lock;
    end
  end

endmodule // cgrpc_top

// ==== logic/cgrpc_regs.vh ====
`ifndef CGRPC_REGS_VH
`define CGRPC_REGS_VH

// control port addresses
`define CGRPC_ADDR_MODE 6'h10
`define CGRPC_ADDR_RATE 6'h11
`define CGRPC_ADDR_PHASE 6'h12

// reset values and writable bits (reserved bits stay zero)
`define CGRPC_MODE_RESET 16'h00ff
`define CGRPC_RATE_RESET 16'hbb80
`define CGRPC_PHASE_RESET 16'h0000
`define CGRPC_MODE_WMASK 16'hfcff
`define CGRPC_PHASE_WMASK 16'h01ff

// mode register fields
`define CGRPC_BIT_REF 15
`define CGRPC_BIT_VID 14
`define CGRPC_BIT_PLLG 13
`define CGRPC_BIT_P200 12
`define CGRPC_BIT_X87 11
`define CGRPC_BIT_C128 10
// phase register direction bit
`define CGRPC_BIT_PDIR 8

// timing
`define CGRPC_CLK_HZ 100000000
`define CGRPC_CLK_KHZ (`CGRPC_CLK_HZ / 1000)
`define CGRPC_PHASE_TICK_KHZ 3072

// bit clock table
`define CGRPC_BIT_STEP_HZ 2400
`define CGRPC_P200_HZ 200
`define CGRPC_X128 128

// conversion rates named by the high nibble
`define CGRPC_CONV_0 7200
`define CGRPC_CONV_1 8400
`define CGRPC_CONV_2 9000
`define CGRPC_CONV_3 9600
`define CGRPC_CONV_4 11200
`define CGRPC_CONV_5 12000
`define CGRPC_CONV_6 12800

// video lock base rates
`define CGRPC_VBASE_48K 48000
`define CGRPC_VBASE_32K 32000
`define CGRPC_VBASE_44K1 44100
`define CGRPC_VBASE_29K4 29400
`define CGRPC_VBASE_44K056 44056

`endif

// ==== logic/cgrpc_rate_decode.v ====
`include "cgrpc_regs.vh"

// pure decode of the rate modifier field into rates
module cgrpc_rate_decode (
  input wire [7:0] rate_modifier_field,
  input wire plus_200hz_modifier,
  output reg [14:0] bit_rate_hz,
  output reg [16:0] named_rate_x7,
  output reg [15:0] video_rate_hz
);

  reg [31:0] tmp_bit;
  reg [31:0] tmp_named;
  reg [31:0] tmp_base;
  reg [31:0] tmp_video;
  reg [3:0] divisor;

  // conversion rate named by high nibble, scaled by 7 so 8/7 stays integer
  function [31:0] named_x7;
    input [3:0] code;
    begin
      case (code)
        4'h0: named_x7 = `CGRPC_CONV_0 * 7;
        4'h1: named_x7 = `CGRPC_CONV_1 * 7;
        4'h2: named_x7 = `CGRPC_CONV_2 * 7;
        4'h3: named_x7 = `CGRPC_CONV_3 * 7;
        4'h4: named_x7 = `CGRPC_CONV_4 * 7;
        4'h5: named_x7 = `CGRPC_CONV_5 * 7;
        4'h6: named_x7 = `CGRPC_CONV_6 * 7;
        4'h7: named_x7 = `CGRPC_CONV_0 * 8;
        4'h8: named_x7 = `CGRPC_CONV_2 * 8;
        4'h9: named_x7 = `CGRPC_CONV_3 * 8;
        4'ha: named_x7 = `CGRPC_CONV_5 * 8;
        4'hf: named_x7 = 7;
        default: named_x7 = 0;
      endcase
    end
  endfunction

  // table decode; reserved codes give zero, which stops the bit clock
  always @* begin
    tmp_bit = 0;
    if (rate_modifier_field == 8'hff) begin
      tmp_bit = `CGRPC_X128;
    end else if (rate_modifier_field[3:0] <= 4'hb) begin
      tmp_bit = (rate_modifier_field[3:0] + 1) * `CGRPC_BIT_STEP_HZ;
      if (plus_200hz_modifier) begin
        tmp_bit = tmp_bit + `CGRPC_P200_HZ;
      end
    end
    bit_rate_hz = tmp_bit[14:0];
    tmp_named = named_x7(rate_modifier_field[7:4]);
    named_rate_x7 = tmp_named[16:0];
  end

  // video lock: base by bits 6:4, ntsc-only codes need bit 7 low
  always @* begin
    case (rate_modifier_field[6:4])
      3'h0: tmp_base = `CGRPC_VBASE_48K;
      3'h1: tmp_base = `CGRPC_VBASE_32K;
      3'h2: tmp_base = `CGRPC_VBASE_44K1;
      3'h3: tmp_base = `CGRPC_VBASE_29K4;
      3'h4: tmp_base = rate_modifier_field[7] ? 0 : `CGRPC_VBASE_48K;
      3'h5: tmp_base = rate_modifier_field[7] ? 0 : `CGRPC_VBASE_44K056;
      default: tmp_base = 0;
    endcase
    divisor = {1'b0, rate_modifier_field[2:0]} + 4'h1;
    tmp_video = tmp_base / {28'h0000000, divisor};
    video_rate_hz = tmp_video[15:0];
  end

endmodule // cgrpc_rate_decode

// ==== testbench/cgrpc_chk.sv ====
`include "cgrpc_regs.vh"

module cgrpc_chk (
  input wire core_clk,
  input wire nrst,
  input wire power_down_n,
  input wire [5:0] ctrl_addr,
  input wire [15:0] ctrl_wdata,
  input wire ctrl_wr,
  input wire ctrl_rd,
  input wire [15:0] ctrl_rdata_r,
  input wire bit_clock_out_r,
  input wire [16:0] conv_rate_hz_r,
  input wire video_mode_r,
  input wire phase_adv_pulse_r,
  input wire phase_ret_pulse_r,
  input wire [15:0] mode_r,
  input wire [15:0] rate_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // 8/7 of the programmed rate, wide enough not to wrap
  wire [19:0] x87 = {4'h0, rate_r} * 20'd8 / 20'd7;
  // multi-step pieces
  sequence s_wr(a); power_down_n && ctrl_wr && ctrl_addr == a; endsequence
  sequence s_vid; (mode_r[15:14] == 2'b11)[*4]; endsequence
  sequence s_quiet; (!phase_adv_pulse_r)[*8]; endsequence
  a_mode_write: assert property (s_wr(6'h10) |=> mode_r == ($past(ctrl_wdata) & `CGRPC_MODE_WMASK))
    else $error("mode write lost");
  a_rate_write: assert property (s_wr(6'h11) |=> rate_r == $past(ctrl_wdata))
    else $error("rate write lost");
  a_pd_defaults: assert property (!power_down_n |=> mode_r == 16'h00ff && rate_r == 16'hbb80)
    else $error("power-down did not restore defaults");
  a_rate_read: assert property (ctrl_rd && ctrl_addr == 6'h11 |=> ctrl_rdata_r == $past(rate_r))
    else $error("rate readback wrong");
  a_video_flag: assert property ($stable(mode_r) |-> video_mode_r == (&mode_r[15:14]))
    else $error("video flag wrong");
  a_video_quiet: assert property (s_vid |-> !bit_clock_out_r)
    else $error("bit clock in video lock");
  a_dir_excl: assert property (!(phase_adv_pulse_r && phase_ret_pulse_r))
    else $error("advance and retard together");
  a_adv_spacing: assert property (phase_adv_pulse_r |=> s_quiet)
    else $error("phase counts too fast");
  a_sync_nophase: assert property ((mode_r[15])[*4] |-> !phase_adv_pulse_r && !phase_ret_pulse_r)
    else $error("phase shift while sync referenced");
  // one-cycle lag, so both registers must have held still
  a_conv_xtal: assert property ($past(nrst) && $stable(mode_r) && $stable(rate_r) && !mode_r[15] |->
    conv_rate_hz_r == (mode_r[11] ? x87[16:0] : {1'b0, rate_r}))
    else $error("conversion rate wrong");
endmodule // cgrpc_chk

bind cgrpc_top cgrpc_chk u_chk (.core_clk, .nrst, .power_down_n, .ctrl_addr, .ctrl_wdata, .ctrl_wr, .ctrl_rd,
  .ctrl_rdata_r, .bit_clock_out_r, .conv_rate_hz_r, .video_mode_r, .phase_adv_pulse_r, .phase_ret_pulse_r,
  .mode_r, .rate_r);

// ==== testbench/tb_top.sv ====
`include "cgrpc_regs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, nrst = 1'b0, power_down_n = 1'b1, ctrl_wr = 1'b0, ctrl_rd = 1'b0;
  logic [5:0] ctrl_addr = 6'h00;
  logic [15:0] ctrl_wdata = 16'h0000;
  wire [15:0] ctrl_rdata_r, mode_r, rate_r;
  wire [16:0] conv_rate_hz_r;
  wire bit_clock_out_r, video_mode_r, phase_adv_pulse_r, phase_ret_pulse_r;
  int num_errors = 0, checks_done = 0;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end

  cgrpc_top uut (.core_clk, .nrst, .power_down_n, .ctrl_addr, .ctrl_wdata, .ctrl_wr, .ctrl_rd,
    .ctrl_rdata_r, .bit_clock_out_r, .conv_rate_hz_r, .video_mode_r, .phase_adv_pulse_r, .phase_ret_pulse_r,
    .mode_r, .rate_r);

  // 100 MHz
  initial forever #5 core_clk = ~core_clk;

  // strobe dropped for a full cycle so back-to-back calls never collide
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    ctrl_addr = a;
    ctrl_wdata = d;
    ctrl_wr = 1'b1;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    ctrl_addr = a;
    ctrl_rd = 1'b1;
    @(negedge core_clk);
    ctrl_rd = 1'b0;
    @(negedge core_clk);
    `CHK(ctrl_rdata_r, e)
  endtask

  // cycles over k bit clock periods; three cycles of slack either way
  task automatic bclk(input int k, input int hz);
    int t, s, r;
    longint e;
    logic p;
    r = 0;
    s = 0;
    p = bit_clock_out_r;
    e = longint'(k) * 100000000 / hz;
    for (t = 0; t < 30000 && r <= k; t++) begin
      @(negedge core_clk);
      if (bit_clock_out_r && !p) begin
        r++;
        if (r == 1) s = t;
      end
      p = bit_clock_out_r;
    end
    `CHK(r > k && (t - 1 - s) >= e - 3 && (t - 1 - s) <= e + 3, 1'b1)
  endtask

  // sample before waiting, so a count taken the cycle after a write is not missed
  task automatic cnt(input int n, output int a, output int r);
    a = 0;
    r = 0;
    repeat (n) begin
      a += phase_adv_pulse_r;
      r += phase_ret_pulse_r;
      @(negedge core_clk);
    end
  endtask

  task automatic t_regs;
    `CHK(mode_r, `CGRPC_MODE_RESET)
    `CHK(rate_r, `CGRPC_RATE_RESET)
    rc(6'h12, 16'h0000);
    wr(6'h10, 16'hff07);
    rc(6'h10, 16'hfc07);
    wr(6'h12, 16'hffff);
    rc(6'h12, 16'h01ff);
    rc(6'h13, 16'h0000);
  endtask

  task automatic t_video;
    logic [7:0] f [7] = '{8'h00, 8'h11, 8'h27, 8'h33, 8'h46, 8'h54, 8'h86};
    int e [7] = '{48000, 32000 / 2, 44100 / 8, 44100 * 2 / 3 / 4, 48000 / 7, 44056 / 5, 48000 / 7};
    for (int i = 0; i < 7; i++) begin
      wr(6'h10, {8'hc0, f[i]});
      `CHK(conv_rate_hz_r, 17'(e[i]))
      `CHK({video_mode_r, bit_clock_out_r}, 2'b10)
    end
  endtask

  task automatic t_bclk;
    wr(6'h11, 16'hd2f0);
    wr(6'h10, 16'h000b);
    bclk(10, 12 * 2400 * 54000 / 7200);
    wr(6'h10, 16'h100b);
    bclk(10, (12 * 2400 + 200) * 54000 / 7200);
    wr(6'h11, 16'h1c20);
    wr(6'h10, 16'h0877);
    bclk(4, 8 * 2400);
    wr(6'h11, 16'h2580);
    wr(6'h10, 16'h00ff);
    bclk(40, 128 * 9600);
    `CHK(conv_rate_hz_r, 17'd9600)
    wr(6'h10, 16'h08ff);
    `CHK(conv_rate_hz_r, 17'(9600 * 8 / 7))
  endtask

  // replace a pending retard by an advance mid-way
  task automatic t_phase;
    int a, r;
    wr(6'h12, 16'h0110);
    cnt(326, a, r);
    `CHK(a == 0 && r >= 9 && r <= 11, 1'b1)
    wr(6'h12, 16'h0003);
    cnt(150, a, r);
    `CHK({a, r}, {32'd3, 32'd0})
    rc(6'h12, 16'h0000);
  endtask

  task automatic t_pd;
    wr(6'h11, 16'h1f40);
    `CHK(rate_r, 16'h1f40)
    power_down_n = 1'b0;
    wr(6'h11, 16'h2000);
    `CHK(bit_clock_out_r, 1'b0)
    `CHK(rate_r, `CGRPC_RATE_RESET)
    `CHK(mode_r, `CGRPC_MODE_RESET)
    power_down_n = 1'b1;
    rc(6'h11, 16'hbb80);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    t_regs;
    t_video;
    t_bclk;
    t_phase;
    t_pd;
    conclude;
  end
endmodule // tb_top
